//--- uart_core.sv
// uart core: baud generator, transmitter, receiver, fifos and host registers
// Notes on behaviour
// - prescaler divides input clock by one, or by four when modem bit 7 set
// - divisor counter divides prescaled clock by 1..65535 giving the 16x tick
// - each transmitted bit stays on the line exactly sixteen ticks
// - frame is start, data bits, optional parity, then one or two stops
// - data bits leave least significant first
// - with fifo enabled each holding write pushes one byte into 32-deep fifo
// - non-fifo: holding empty sets when byte moves into the shifter
// - non-fifo: holding empty raises transmit interrupt only when enabled
// - non-fifo: transmitter empty sets once holding is empty and shifter has finished its character
// - fifo mode: holding empty sets whenever transmit fifo is empty
// - fifo mode: transmit interrupt when fill drops below transmit trigger
// - fifo mode: transmitter empty needs both fifo and shifter empty
// - start bit accepted only if line still low eight ticks after fall
// - data, parity and stop bits sampled at their centres
// - with fifo enabled receive fifo holds 32 entries of character plus three error tags
// - reading receive data pops fifo; status tags follow the next character
// - receive register always shows the oldest unread character
// - data ready interrupt per character, or at trigger level when feature bit set in fifo mode
// - unread data and four words plus twelve bits idle raise timeout
// - two line-control bits pick five to eight data bits
module word_fifo #(
	parameter int W  = 8,
	parameter int D  = 32,
	parameter int AW = $clog2(D)
) (
	input  wire logic          clock_i,
	input  wire logic          nrst_i,
	input  wire logic          clr_i,
	input  wire logic [AW:0]   limit_i,
	input  wire logic          in_valid_i,
	output logic               in_ready_o,
	input  wire logic [W-1:0]  in_data_i,
	output logic               out_valid_o,
	input  wire logic          out_ready_i,
	output logic [W-1:0]       out_data_o,
	output logic [AW:0]        count_o
);
	// depth must be a power of two: pointers wrap by overflow
	logic [W-1:0]  mem_q [D];
	logic [W-1:0]  mem_d [D];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0]   cnt_q, cnt_d;
	logic          push, pop;
	assign in_ready_o  = cnt_q < limit_i;
	assign out_valid_o = cnt_q != '0;
	assign out_data_o  = mem_q[rp_q];
	assign count_o     = cnt_q;
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	always_comb begin
		mem_d = mem_q;
		wp_d  = wp_q;
		rp_d  = rp_q;
		if (push) begin
			mem_d[wp_q] = in_data_i;
			wp_d        = wp_q + 1'b1;
		end
		if (pop) begin
			rp_d = rp_q + 1'b1;
		end
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		if (clr_i) begin
			wp_d  = '0;
			rp_d  = '0;
			cnt_d = '0;
		end
	end
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mem_q <= '{default: '0};
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			mem_q <= mem_d;
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
	end
endmodule

module uart_core
	import uart_pkg::*;
#(
	parameter int FIFO_DEPTH = 32
) (
	input  wire logic       clock_i,
	input  wire logic       nrst_i,
	input  wire logic [2:0] addr_i,
	input  wire logic       cs_n_i,
	input  wire logic       rd_n_i,
	input  wire logic       wr_n_i,
	input  wire logic [7:0] data_i,
	output logic [7:0]      data_o,
	output logic            data_oe_n_o,
	output logic            int_o,
	output logic            tx_o,
	input  wire logic       rx_i
);
	localparam int CW = $clog2(FIFO_DEPTH) + 1;
	logic [14:0] pin_s1_q, pin_s2_q;
	logic        rd_prv_q, wr_prv_q, rx_prv_q;
	logic        rd_act, wr_act, rd_end, wr_end, rx_s, dlab, fen;
	logic [2:0]  addr_s;
	logic [7:0]  din_s;
	logic [7:0]  ier_q, ier_d, lcr_q, lcr_d, mcr_q, mcr_d, fcr_q, fcr_d, xfr_q, xfr_d;
	logic [7:0]  dll_q, dll_d, dlm_q, dlm_d, dout_q, dout_d, line_status;
	logic        oe_n_q, oe_n_d, int_q, int_d, ovr_q, ovr_d;
	logic        rclr_q, rclr_d, tclr_q, tclr_d;
	logic [3:0]  interrupt_source_reg;
	logic        rx_trig, tx_trig, thre, temt;
	logic [1:0]  pre_q, pre_d;
	logic [15:0] div_q, div_d;
	logic        pre_tick, tick16;
	logic [CW-1:0] lim, tx_cnt, rx_cnt;
	logic        tx_valid, tx_pop, tx_push, rx_valid, rx_pop, bufo_valid, rxf_ready, buf_ready;
	logic [7:0]  tx_dout;
	logic [10:0] rx_out, bufo_data;
	logic [2:0]  nbits_m1;
	ser_state_t  txs_q, txs_d, rxs_q, rxs_d;
	logic [7:0]  tsh_q, tsh_d, rsh_q, rsh_d;
	logic [3:0]  tcnt_q, tcnt_d, rcnt_q, rcnt_d;
	logic [2:0]  tbit_q, tbit_d, rbit_q, rbit_d, tnext;
	logic        tpar_q, tpar_d, tx_q, tx_d, tlast, stop_done;
	logic        rpar_q, rpar_d, perr_q, perr_d, rpush_q, rpush_d, rmid;
	logic [10:0] rword_q, rword_d;
	logic [9:0]  to_cnt_q, to_cnt_d, to_lim;
	logic        to_q, to_d, rx_evt;

	// every pin passes two flops; only the second stage is looked at
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_s1_q <= 15'h7001;
			pin_s2_q <= 15'h7001;
			rd_prv_q <= 1'b0;
			wr_prv_q <= 1'b0;
			rx_prv_q <= 1'b1;
		end else begin
			pin_s1_q <= {cs_n_i, rd_n_i, wr_n_i, addr_i, data_i, rx_i};
			pin_s2_q <= pin_s1_q;
			rd_prv_q <= rd_act;
			wr_prv_q <= wr_act;
			rx_prv_q <= rx_s;
		end
	end
	assign rd_act   = !pin_s2_q[14] && !pin_s2_q[13];
	assign wr_act   = !pin_s2_q[14] && !pin_s2_q[12];
	assign addr_s   = pin_s2_q[11:9];
	assign din_s    = pin_s2_q[8:1];
	assign rx_s     = pin_s2_q[0];
	// side effects act at the end of the strobe so the host has seen the data
	assign rd_end   = rd_prv_q && !rd_act;
	assign wr_end   = wr_prv_q && !wr_act;
	assign dlab     = lcr_q[LCR_DLAB];
	assign fen      = fcr_q[FCR_EN];
	assign lim      = fen ? CW'(FIFO_DEPTH) : CW'(1);
	assign nbits_m1 = {1'b0, lcr_q[1:0]} + MIN_BITS;

	assign tx_push = wr_end && addr_s == ADR_DATA && !dlab;
	assign rx_pop  = rd_end && addr_s == ADR_DATA && !dlab;
	assign thre    = tx_cnt == '0;
	assign temt    = thre && txs_q == S_IDLE;
	assign line_status     = {1'b0, temt, thre, rx_valid ? rx_out[10:8] : 3'h0, ovr_q, rx_valid};
	assign rx_trig = (fen && xfr_q[XFR_TRIG]) ? rx_cnt >= CW'(trig_lvl(fcr_q[7:6]))
		: rx_valid;
	assign tx_trig = fen ? tx_cnt < CW'(trig_lvl(fcr_q[5:4])) : thre;
	assign interrupt_source_reg = (to_q && ier_q[IER_RX]) ? ISR_TO :
		(rx_trig && ier_q[IER_RX]) ? ISR_RX :
		(tx_trig && ier_q[IER_TX]) ? ISR_TX : ISR_NONE;

	always_comb begin
		ier_d  = ier_q;
		lcr_d  = lcr_q;
		mcr_d  = mcr_q;
		fcr_d  = fcr_q;
		xfr_d  = xfr_q;
		dll_d  = dll_q;
		dlm_d  = dlm_q;
		rclr_d = 1'b0;
		tclr_d = 1'b0;
		ovr_d  = ovr_q;
		if (rd_end && addr_s == ADR_LSR) begin
			ovr_d = 1'b0;
		end
		// a character lost in the same cycle as the status read stays flagged
		if (rpush_q && !buf_ready) begin
			ovr_d = 1'b1;
		end
		if (wr_end) begin
			case (addr_s)
				ADR_DATA: if (dlab) dll_d = din_s;
				ADR_IER: begin
					if (dlab) dlm_d = din_s;
					else ier_d = din_s;
				end
				ADR_ISR: begin
					fcr_d  = din_s;
					rclr_d = din_s[FCR_RCLR] || (din_s[FCR_EN] != fcr_q[FCR_EN]);
					tclr_d = din_s[FCR_TCLR] || (din_s[FCR_EN] != fcr_q[FCR_EN]);
				end
				ADR_LCR: lcr_d = din_s;
				ADR_MCR: mcr_d = din_s;
				ADR_XFR: xfr_d = din_s;
				default: ;
			endcase
		end
		case (addr_s)
			ADR_DATA: dout_d = dlab ? dll_q : rx_out[7:0];
			ADR_IER:  dout_d = dlab ? dlm_q : ier_q;
			ADR_ISR:  dout_d = {fen, fen, 2'h0, interrupt_source_reg};
			ADR_LCR:  dout_d = lcr_q;
			ADR_MCR:  dout_d = mcr_q;
			ADR_LSR:  dout_d = line_status;
			ADR_XFR:  dout_d = xfr_q;
			default:  dout_d = REG_RST;
		endcase
		oe_n_d = !rd_act;
		int_d  = interrupt_source_reg != ISR_NONE;
	end
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ier_q  <= REG_RST;
			lcr_q  <= REG_RST;
			mcr_q  <= REG_RST;
			fcr_q  <= REG_RST;
			xfr_q  <= REG_RST;
			dll_q  <= DIV_RST[7:0];
			dlm_q  <= DIV_RST[15:8];
			dout_q <= REG_RST;
			oe_n_q <= 1'b1;
			int_q  <= 1'b0;
			ovr_q  <= 1'b0;
			rclr_q <= 1'b0;
			tclr_q <= 1'b0;
		end else begin
			ier_q  <= ier_d;
			lcr_q  <= lcr_d;
			mcr_q  <= mcr_d;
			fcr_q  <= fcr_d;
			xfr_q  <= xfr_d;
			dll_q  <= dll_d;
			dlm_q  <= dlm_d;
			dout_q <= dout_d;
			oe_n_q <= oe_n_d;
			int_q  <= int_d;
			ovr_q  <= ovr_d;
			rclr_q <= rclr_d;
			tclr_q <= tclr_d;
		end
	end
	assign data_o      = dout_q;
	assign data_oe_n_o = oe_n_q;
	assign int_o       = int_q;

	// baud generator; divisor zero behaves as one
	assign pre_tick = !mcr_q[MCR_PRE] || pre_q == PRE_LAST;
	assign tick16   = pre_tick && (div_q + 16'h0001) >= {dlm_q, dll_q};
	always_comb begin
		pre_d = pre_tick ? 2'h0 : pre_q + 2'h1;
		div_d = div_q;
		if (pre_tick) begin
			div_d = tick16 ? 16'h0000 : div_q + 16'h0001;
		end
	end
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pre_q <= 2'h0;
			div_q <= 16'h0000;
		end else begin
			pre_q <= pre_d;
			div_q <= div_d;
		end
	end

	word_fifo #(.W(8), .D(FIFO_DEPTH)) u_txf (
		.clock_i(clock_i), .nrst_i(nrst_i), .clr_i(tclr_q), .limit_i(lim),
		.in_valid_i(tx_push), .in_ready_o(), .in_data_i(din_s),
		.out_valid_o(tx_valid), .out_ready_i(tx_pop), .out_data_o(tx_dout),
		.count_o(tx_cnt)
	);

	// transmitter; a new frame starts only on a tick so the start bit is whole
	assign tlast     = tick16 && tcnt_q == BIT_LAST;
	assign stop_done = txs_q == S_STOP && tlast && !(lcr_q[LCR_STOP] && tbit_q == 3'h0);
	assign tx_pop    = tx_valid && tick16 && (txs_q == S_IDLE || stop_done);
	assign tnext     = tbit_q + 3'h1;
	always_comb begin
		txs_d  = txs_q;
		tsh_d  = tsh_q;
		tcnt_d = tcnt_q;
		tbit_d = tbit_q;
		tpar_d = tpar_q;
		tx_d   = tx_q;
		if (txs_q != S_IDLE && tick16) begin
			tcnt_d = tcnt_q + 4'h1;
		end
		case (txs_q)
			S_IDLE, S_STOP: begin
				if (txs_q == S_STOP && tlast && !stop_done) begin
					tbit_d = 3'h1;
				end else if (tx_pop) begin
					tsh_d  = tx_dout;
					txs_d  = S_START;
					tx_d   = 1'b0;
					tcnt_d = 4'h0;
					tpar_d = !lcr_q[LCR_EVEN];
				end else if (stop_done) begin
					txs_d = S_IDLE;
				end
			end
			S_START: if (tlast) begin
				txs_d  = S_DATA;
				tbit_d = 3'h0;
				tx_d   = tsh_q[0];
				tpar_d = tpar_q ^ tsh_q[0];
			end
			S_DATA: if (tlast) begin
				if (tbit_q == nbits_m1) begin
					txs_d  = lcr_q[LCR_PEN] ? S_PAR : S_STOP;
					tx_d   = lcr_q[LCR_PEN] ? tpar_q : 1'b1;
					tbit_d = 3'h0;
				end else begin
					tbit_d = tnext;
					tx_d   = tsh_q[tnext];
					tpar_d = tpar_q ^ tsh_q[tnext];
				end
			end
			S_PAR: if (tlast) begin
				txs_d = S_STOP;
				tx_d  = 1'b1;
			end
			default: txs_d = S_IDLE;
		endcase
	end
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			txs_q  <= S_IDLE;
			tsh_q  <= 8'h00;
			tcnt_q <= 4'h0;
			tbit_q <= 3'h0;
			tpar_q <= 1'b0;
			tx_q   <= 1'b1;
		end else begin
			txs_q  <= txs_d;
			tsh_q  <= tsh_d;
			tcnt_q <= tcnt_d;
			tbit_q <= tbit_d;
			tpar_q <= tpar_d;
			tx_q   <= tx_d;
		end
	end
	assign tx_o = tx_q;

	// receiver; tags are {break, framing, parity}
	assign rmid = tick16 && rcnt_q == BIT_LAST;
	always_comb begin
		rxs_d   = rxs_q;
		rsh_d   = rsh_q;
		rcnt_d  = rcnt_q;
		rbit_d  = rbit_q;
		rpar_d  = rpar_q;
		perr_d  = perr_q;
		rpush_d = 1'b0;
		rword_d = rword_q;
		if (rxs_q != S_IDLE && tick16) begin
			rcnt_d = rcnt_q + 4'h1;
		end
		case (rxs_q)
			S_IDLE: if (rx_prv_q && !rx_s) begin
				rxs_d  = S_START;
				rcnt_d = 4'h0;
				rsh_d  = 8'h00;
				perr_d = 1'b0;
				rpar_d = !lcr_q[LCR_EVEN];
			end
			S_START: if (tick16 && rcnt_q == MID_LAST) begin
				rxs_d  = rx_s ? S_IDLE : S_DATA;
				rcnt_d = 4'h0;
				rbit_d = 3'h0;
			end
			S_DATA: if (rmid) begin
				rsh_d[rbit_q] = rx_s;
				rpar_d = rpar_q ^ rx_s;
				rbit_d = rbit_q + 3'h1;
				if (rbit_q == nbits_m1) begin
					rxs_d = lcr_q[LCR_PEN] ? S_PAR : S_STOP;
				end
			end
			S_PAR: if (rmid) begin
				perr_d = rx_s != rpar_q;
				rxs_d  = S_STOP;
			end
			S_STOP: if (rmid) begin
				rpush_d = 1'b1;
				rword_d = {!rx_s && rsh_q == 8'h00, !rx_s, perr_q, rsh_q};
				rxs_d   = S_IDLE;
			end
			default: rxs_d = S_IDLE;
		endcase
	end
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rxs_q   <= S_IDLE;
			rsh_q   <= 8'h00;
			rcnt_q  <= 4'h0;
			rbit_q  <= 3'h0;
			rpar_q  <= 1'b0;
			perr_q  <= 1'b0;
			rpush_q <= 1'b0;
			rword_q <= 11'h000;
		end else begin
			rxs_q   <= rxs_d;
			rsh_q   <= rsh_d;
			rcnt_q  <= rcnt_d;
			rbit_q  <= rbit_d;
			rpar_q  <= rpar_d;
			perr_q  <= perr_d;
			rpush_q <= rpush_d;
			rword_q <= rword_d;
		end
	end

	// two-entry buffer absorbs a fifo stall; only a third word becomes an overrun
	word_fifo #(.W(11), .D(2)) u_rxbuf (
		.clock_i(clock_i), .nrst_i(nrst_i), .clr_i(rclr_q), .limit_i(2'h2),
		.in_valid_i(rpush_q), .in_ready_o(buf_ready), .in_data_i(rword_q),
		.out_valid_o(bufo_valid), .out_ready_i(rxf_ready), .out_data_o(bufo_data),
		.count_o()
	);
	word_fifo #(.W(11), .D(FIFO_DEPTH)) u_rxf (
		.clock_i(clock_i), .nrst_i(nrst_i), .clr_i(rclr_q), .limit_i(lim),
		.in_valid_i(bufo_valid), .in_ready_o(rxf_ready), .in_data_i(bufo_data),
		.out_valid_o(rx_valid), .out_ready_i(rx_pop), .out_data_o(rx_out),
		.count_o(rx_cnt)
	);

	// timeout counts 16x ticks; a new character or a read restarts it
	assign to_lim = {({4'h0, lcr_q[1:0]} + CHR_BASE) * TO_WORDS + TO_EXTRA, 4'h0};
	assign rx_evt = rx_pop || (bufo_valid && rxf_ready) || rclr_q || !rx_valid;
	always_comb begin
		to_cnt_d = to_cnt_q;
		to_d     = to_q;
		if (rx_evt) begin
			to_cnt_d = 10'h000;
			to_d     = 1'b0;
		end else if (tick16 && !to_q) begin
			to_cnt_d = to_cnt_q + 10'h001;
			to_d     = to_cnt_q == to_lim - 10'h001;
		end
	end
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			to_cnt_q <= 10'h000;
			to_q     <= 1'b0;
		end else begin
			to_cnt_q <= to_cnt_d;
			to_q     <= to_d;
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	property p_pre4;
		mcr_q[MCR_PRE] && pre_tick |=> (!pre_tick || !mcr_q[MCR_PRE]) [*3];
	endproperty
	a_pre4: assert property (p_pre4) else $error("prescaler not dividing by four");
	property p_bit16;
		$changed(txs_q) && $past(txs_q) != S_IDLE |-> $past(tcnt_q == BIT_LAST && tick16);
	endproperty
	a_bit16: assert property (p_bit16) else $error("tx bit not sixteen ticks");
	property p_lsb;
		$rose(txs_q == S_DATA) |-> tx_q == tsh_q[0] && tbit_q == 3'h0;
	endproperty
	a_lsb: assert property (p_lsb) else $error("first data bit not bit zero");
	property p_len;
		$changed(txs_q) && $past(txs_q) == S_DATA |-> $past(tbit_q) == nbits_m1;
	endproperty
	a_len: assert property (p_len) else $error("wrong character length");
	property p_reject;
		rxs_q == S_START && tick16 && rcnt_q == MID_LAST && rx_s |=> rxs_q == S_IDLE && !rpush_q;
	endproperty
	a_reject: assert property (p_reject) else $error("false start not rejected");
	property p_accept;
		$rose(rxs_q == S_DATA) |-> $past(!rx_s && tick16 && rcnt_q == MID_LAST);
	endproperty
	a_accept: assert property (p_accept) else $error("start accepted off centre");
	property p_thre;
		!fen && tx_pop |=> thre ##0 txs_q == S_START;
	endproperty
	a_thre: assert property (p_thre) else $error("holding empty not set on load");
	property p_temt;
		temt |-> thre && tx_q;
	endproperty
	a_temt: assert property (p_temt) else $error("tx empty with data left");
	property p_rxint;
		ier_q[IER_RX] && rx_valid && !(fen && xfr_q[XFR_TRIG]) |=> int_q;
	endproperty
	a_rxint: assert property (p_rxint) else $error("data ready interrupt missing");
	property p_to;
		to_q |-> rx_valid;
	endproperty
	a_to: assert property (p_to) else $error("timeout without unread data");
	c_txframe: cover property (stop_done);
	c_rxchar: cover property (rpush_q && buf_ready);
	c_timeout: cover property ($rose(to_q));
	c_reject: cover property (rxs_q == S_START ##1 rxs_q == S_IDLE);
endmodule

//--- uart_pkg.sv
// package: register map, field positions and timing constants of the uart core
package uart_pkg;
	localparam logic [2:0] ADR_DATA = 3'h0;
	localparam logic [2:0] ADR_IER  = 3'h1;
	localparam logic [2:0] ADR_ISR  = 3'h2;
	localparam logic [2:0] ADR_LCR  = 3'h3;
	localparam logic [2:0] ADR_MCR  = 3'h4;
	localparam logic [2:0] ADR_LSR  = 3'h5;
	localparam logic [2:0] ADR_XFR  = 3'h7;
	localparam int IER_RX   = 0;
	localparam int IER_TX   = 1;
	localparam int FCR_EN   = 0;
	localparam int FCR_RCLR = 1;
	localparam int FCR_TCLR = 2;
	localparam int LCR_STOP = 2;
	localparam int LCR_PEN  = 3;
	localparam int LCR_EVEN = 4;
	localparam int LCR_DLAB = 7;
	localparam int MCR_PRE  = 7;
	localparam int XFR_TRIG = 3;
	localparam logic [7:0]  REG_RST  = 8'h00;
	localparam logic [15:0] DIV_RST  = 16'h0001;
	localparam logic [1:0]  PRE_LAST = 2'h3;
	localparam logic [3:0]  BIT_LAST = 4'hF;
	localparam logic [3:0]  MID_LAST = 4'h7;
	localparam logic [2:0]  MIN_BITS = 3'h4;
	localparam logic [5:0]  CHR_BASE = 6'h05;
	localparam logic [5:0]  TO_WORDS = 6'h04;
	localparam logic [5:0]  TO_EXTRA = 6'h0C;
	localparam logic [3:0]  ISR_NONE = 4'h1;
	localparam logic [3:0]  ISR_TX   = 4'h2;
	localparam logic [3:0]  ISR_RX   = 4'h4;
	localparam logic [3:0]  ISR_TO   = 4'hC;
	typedef enum logic [2:0] {
		S_IDLE  = 3'h0,
		S_START = 3'h1,
		S_DATA  = 3'h3,
		S_PAR   = 3'h2,
		S_STOP  = 3'h6
	} ser_state_t;
	function automatic logic [5:0] trig_lvl(input logic [1:0] sel);
		case (sel)
			2'h0:    trig_lvl = 6'h08;
			2'h1:    trig_lvl = 6'h10;
			2'h2:    trig_lvl = 6'h18;
			default: trig_lvl = 6'h1C;
		endcase
	endfunction
endpackage

//--- uart_remote.sv
// remote serial partner: decodes the core's transmit line and drives its receive line
module uart_remote (
	input  wire logic       clock_i,
	input  wire logic       line_i,
	output logic            line_o,
	input  wire logic [3:0] nbits_i,
	input  wire logic [7:0] bitc_i,
	input  wire logic       req_i,
	input  wire logic [7:0] byte_i,
	input  wire logic [1:0] kind_i,
	output logic            done_o,
	output logic [7:0]      got_o,
	output logic            got_stb_o,
	output logic [7:0]      width_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] run_q = 8'h00;
	logic [7:0] sh;
	int         i;
	int         j;
	// low run length; a byte with bit 0 set shows the start bit alone
	always @(posedge clock_i) begin
		if (line_i === 1'b0) begin
			run_q <= run_q + 8'h01;
		end else if (run_q != 8'h00) begin
			width_o <= run_q;
			run_q   <= 8'h00;
		end
	end
	// decode at bit centres, lsb first, stop bit must be high
	initial begin
		got_o = 8'h00;
		got_stb_o = 1'b0;
		forever begin
			@(negedge line_i);
			repeat (bitc_i / 2) @(posedge clock_i);
			if (line_i === 1'b0) begin
				sh = 8'h00;
				for (i = 0; i < nbits_i; i++) begin
					repeat (bitc_i) @(posedge clock_i);
					sh[i] = line_i;
				end
				repeat (bitc_i) @(posedge clock_i);
				got_o = (line_i === 1'b1) ? sh : 8'hEE;
				got_stb_o = 1'b1;
				@(posedge clock_i);
				got_stb_o = 1'b0;
			end
		end
	end
	// kind 0 good frame, 1 stop bit held low, 2 short false start
	initial begin
		line_o = 1'b1;
		done_o = 1'b0;
		forever begin
			@(posedge clock_i);
			if (req_i && !done_o) begin
				line_o <= 1'b0;
				if (kind_i == 2'h2) begin
					repeat (4) @(posedge clock_i);
				end else begin
					repeat (bitc_i) @(posedge clock_i);
					for (j = 0; j < nbits_i; j++) begin
						line_o <= byte_i[j];
						repeat (bitc_i) @(posedge clock_i);
					end
					line_o <= (kind_i != 2'h1);
					repeat (bitc_i) @(posedge clock_i);
				end
				line_o <= 1'b1;
				done_o <= 1'b1;
			end else if (!req_i) begin
				done_o <= 1'b0;
			end
		end
	end
endmodule

//--- testbench.sv
// self-checking bench of the uart core against a remote serial partner
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import uart_pkg::*;
	logic       clock_i = 1'b0;
	logic       nrst_i = 1'b0;
	logic [2:0] addr_i = 3'h0;
	logic       cs_n_i = 1'b1;
	logic       rd_n_i = 1'b1;
	logic       wr_n_i = 1'b1;
	logic [7:0] data_i = 8'h00;
	logic [7:0] data_o;
	logic       data_oe_n_o;
	logic       int_o;
	logic       tx_o;
	logic       rx_i;
	logic [3:0] nbits = 4'h8;
	logic [7:0] bitc = 8'h10;
	logic       req = 1'b0;
	logic [7:0] sbyte = 8'h00;
	logic [1:0] kind = 2'h0;
	logic       done;
	logic [7:0] got;
	logic       got_stb;
	logic [7:0] width;
	logic [7:0] rv;
	logic [7:0] rxq[$];
	int         err_total = 0;
	int         n_tests = 0;
	int         cyc = 0;
	int         k;
	always #12.5 clock_i = ~clock_i;
	uart_core u_dut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .cs_n_i(cs_n_i),
		.rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .data_i(data_i), .data_o(data_o),
		.data_oe_n_o(data_oe_n_o), .int_o(int_o), .tx_o(tx_o), .rx_i(rx_i));
	uart_remote u_remote (.clock_i(clock_i), .line_i(tx_o), .line_o(rx_i), .nbits_i(nbits),
		.bitc_i(bitc), .req_i(req), .byte_i(sbyte), .kind_i(kind), .done_o(done),
		.got_o(got), .got_stb_o(got_stb), .width_o(width));
	always @(posedge got_stb) rxq.push_back(got);
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// generous ceiling: the longest path is about twenty frames plus one idle timeout
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("Error at %0t: got %0h expected %0h", $time, g, e);
		end
	endtask
	// strobes held four clocks, address and data held four more after release
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		data_i <= d;
		cs_n_i <= 1'b0;
		wr_n_i <= 1'b0;
		repeat (4) @(posedge clock_i);
		cs_n_i <= 1'b1;
		wr_n_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		// step off the edge so outputs launched there are seen settled
		#1;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		cs_n_i <= 1'b0;
		rd_n_i <= 1'b0;
		repeat (5) @(posedge clock_i);
		#1;
		d = data_o;
		chk({7'h00, data_oe_n_o}, 8'h00);
		@(posedge clock_i);
		cs_n_i <= 1'b1;
		rd_n_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		#1;
	endtask
	task automatic send(input logic [7:0] b, input logic [1:0] kd);
		@(posedge clock_i);
		sbyte <= b;
		kind <= kd;
		req <= 1'b1;
		for (k = 0; k < 5000 && done !== 1'b1; k++) @(posedge clock_i);
		req <= 1'b0;
		repeat (3) @(posedge clock_i);
	endtask
	task automatic wait_rx(input int n);
		for (k = 0; k < 20000 && rxq.size() < n; k++) @(posedge clock_i);
		chk(8'(rxq.size()), 8'(n));
	endtask
	task automatic t_reset();
		chk({7'h00, tx_o}, 8'h01);
		chk({7'h00, int_o}, 8'h00);
		rd(ADR_LSR, rv);
		chk(rv, 8'h60);
	endtask
	// 40 MHz / 1 / (16 * 2.5 Mbit/s) gives divisor 1
	task automatic set_div(input logic [7:0] d);
		wr(ADR_LCR, 8'h83);
		wr(ADR_DATA, d);
		wr(ADR_IER, 8'h00);
		wr(ADR_LCR, 8'h03);
	endtask
	task automatic t_tx_basic();
		rxq.delete();
		wr(ADR_DATA, 8'hFF);
		rd(ADR_LSR, rv);
		chk(rv, 8'h20);
		wr(ADR_DATA, 8'hA5);
		wait_rx(2);
		chk(rxq[1], 8'hA5);
		chk(width, 8'h10);
		repeat (200) @(posedge clock_i);
		rd(ADR_LSR, rv);
		chk(rv, 8'h60);
	endtask
	task automatic t_len();
		for (int n = 0; n < 4; n++) begin
			rxq.delete();
			wr(ADR_LCR, 8'(n));
			nbits = 4'(n + 5);
			wr(ADR_DATA, 8'hB6);
			wait_rx(1);
			chk(rxq[0], 8'hB6 & 8'((1 << (n + 5)) - 1));
		end
		// seven data bits plus parity read back as one eight-bit character
		rxq.delete();
		wr(ADR_LCR, 8'h0A);
		wr(ADR_DATA, 8'h35);
		wait_rx(1);
		chk(rxq[0], 8'hB5);
		wr(ADR_LCR, 8'h1A);
		wr(ADR_DATA, 8'h35);
		wait_rx(2);
		chk(rxq[1], 8'h35);
	endtask
	task automatic t_baud();
		rxq.delete();
		wr(ADR_MCR, 8'h80);
		bitc = 8'h40;
		wr(ADR_DATA, 8'hFF);
		wait_rx(1);
		chk(width, 8'h40);
		wr(ADR_MCR, 8'h00);
		set_div(8'h03);
		bitc = 8'h30;
		wr(ADR_DATA, 8'hFF);
		wait_rx(2);
		chk(width, 8'h30);
		set_div(8'h01);
		bitc = 8'h10;
	endtask
	task automatic t_fifo_tx();
		wr(ADR_ISR, 8'h01);
		rxq.delete();
		for (int i = 1; i < 5; i++) wr(ADR_DATA, 8'(i * 17));
		rd(ADR_LSR, rv);
		chk(rv, 8'h00);
		wait_rx(4);
		for (int i = 1; i < 5; i++) chk(rxq[i - 1], 8'(i * 17));
		repeat (200) @(posedge clock_i);
		rd(ADR_LSR, rv);
		chk(rv, 8'h60);
	endtask
	task automatic t_tx_int();
		wr(ADR_IER, 8'h02);
		chk({7'h00, int_o}, 8'h01);
		rd(ADR_ISR, rv);
		chk(rv, 8'hC2);
		wr(ADR_ISR, 8'h00);
		rd(ADR_ISR, rv);
		chk(rv, 8'h02);
		wr(ADR_IER, 8'h00);
		chk({7'h00, int_o}, 8'h00);
		wr(ADR_ISR, 8'h01);
	endtask
	task automatic t_rx();
		send(8'h3C, 2'h0);
		send(8'h5A, 2'h1);
		rd(ADR_LSR, rv);
		chk(rv, 8'h61);
		rd(ADR_DATA, rv);
		chk(rv, 8'h3C);
		rd(ADR_LSR, rv);
		chk(rv, 8'h69);
		rd(ADR_DATA, rv);
		chk(rv, 8'h5A);
		rd(ADR_LSR, rv);
		chk(rv, 8'h60);
		// odd parity expected, bit 7 of the sent byte arrives as a wrong parity bit
		wr(ADR_LCR, 8'h0A);
		send(8'h35, 2'h0);
		rd(ADR_LSR, rv);
		chk(rv, 8'h65);
		rd(ADR_DATA, rv);
		chk(rv, 8'h35);
		wr(ADR_LCR, 8'h03);
	endtask
	task automatic t_false_start();
		send(8'h00, 2'h2);
		repeat (100) @(posedge clock_i);
		rd(ADR_LSR, rv);
		chk(rv, 8'h60);
		send(8'h81, 2'h0);
		rd(ADR_DATA, rv);
		chk(rv, 8'h81);
	endtask
	task automatic t_rx_int();
		wr(ADR_IER, 8'h01);
		send(8'h77, 2'h0);
		chk({7'h00, int_o}, 8'h01);
		rd(ADR_ISR, rv);
		chk(rv, 8'hC4);
		rd(ADR_DATA, rv);
		chk({7'h00, int_o}, 8'h00);
		wr(ADR_XFR, 8'h08);
		send(8'h66, 2'h0);
		chk({7'h00, int_o}, 8'h00);
		repeat (1200) @(posedge clock_i);
		rd(ADR_ISR, rv);
		chk(rv, 8'hCC);
		rd(ADR_DATA, rv);
		chk(rv, 8'h66);
		chk({7'h00, int_o}, 8'h00);
	endtask
	initial begin
		repeat (12) @(posedge clock_i);
		nrst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		t_reset();
		set_div(8'h01);
		t_tx_basic();
		t_len();
		wr(ADR_LCR, 8'h03);
		nbits = 4'h8;
		t_baud();
		t_fifo_tx();
		t_tx_int();
		t_rx();
		t_false_start();
		t_rx_int();
		report_and_stop();
	end
endmodule
